//--- dac_channel_control.sv
// Top of the DAC channel control block with its APB register file
//
// Behaviour
// - twelve channels, each with 12-bit code
// - reference source selectable, internal after reset
// - outputs inactive until reference block enabled
// - channel drives only while its power set
// - gain resets to twice-reference range
// - gain bit selects five-times-reference range
// - enabled low clear pin clears channel
// - software clear bit forces clear state
// - auto-clear enters clear on enabled trigger
// - sync load waits for latch command
`timescale 1ns/1ps
module dac_channel_control
   import dac_ctrl_pkg::*;
#(
   parameter int CHANNELS = NUM_CH,              // Channel count
   parameter int CW = CODE_W                     // Code width
) (
   input wire logic pclk,                        // APB clock
   input wire logic presetn,                     // Async reset, active low
   input wire logic psel,                        // APB select
   input wire logic penable,                     // APB enable
   input wire logic pwrite,                      // APB direction
   input wire logic [ADDR_W-1:0] paddr,          // APB byte address
   input wire logic [31:0] pwdata,               // APB write data
   input wire logic [3:0] pstrb,                 // APB byte strobes
   output logic [31:0] prdata,                   // APB read data
   output logic pready,                          // APB ready
   output logic pslverr,                         // APB error
   input wire logic clear_input0_n,              // Clear pin 0, active low
   input wire logic clear_input1_n,              // Clear pin 1, active low
   input wire logic [3:0] input_range_trigger,   // Input channel 0..3 out of range
   input wire logic local_temp_high_trigger,     // Local temperature high
   input wire logic local_temp_low_trigger,      // Local temperature low
   input wire logic remote1_fail_trigger,        // Remote sensor 1 fail
   input wire logic remote1_high_trigger,        // Remote sensor 1 high
   input wire logic remote1_low_trigger,         // Remote sensor 1 low
   input wire logic remote2_fail_trigger,        // Remote sensor 2 fail
   input wire logic remote2_high_trigger,        // Remote sensor 2 high
   input wire logic remote2_low_trigger,         // Remote sensor 2 low
   input wire logic overtemperature_trigger,     // Overtemperature
   output logic [CHANNELS*CW-1:0] dac_code,      // Code per channel, packed
   output logic [CHANNELS-1:0] dac_active,       // Channel output driven
   output logic [CHANNELS-1:0] dac_high_range,   // 1 = five-times range
   output logic ref_external                     // 1 = external reference
);
   // ****************************************
   // Types and helper functions
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,                          // No transfer
      ST_LOAD = 3'b010,                          // Copy buffer to latch
      ST_DONE = 3'b100                           // Walk finished
   } load_state_t;

   // Does an address hit one register
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Is the address inside a per-channel bank
   function automatic logic in_bank(input logic [ADDR_W-1:0] a, input logic [11:0] base);
      in_bank = (a >= base) && (a < base + DATA_SPAN) && (a[1:0] == 2'b00);
   endfunction : in_bank

   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] ctrl;                            // Reference control
   logic [CHANNELS-1:0] channel_power_enable;    // Power per channel
   logic [CHANNELS-1:0] gain;                    // Range per channel
   logic [CHANNELS-1:0] pin0_clear_enable;       // Pin 0 clear enable
   logic [CHANNELS-1:0] pin1_clear_enable;       // Pin 1 clear enable
   logic [CHANNELS-1:0] software_clear;          // Software clear
   logic [CHANNELS-1:0] trigger_clear_enable;    // Auto clear
   logic [CHANNELS-1:0] sync_load_enable;        // Sync load
   logic [NUM_TRIG-1:0] trigger_enable;          // Enabled trigger sources
   logic [CHANNELS*CW-1:0] out_latch;            // Output latches
   logic [CHANNELS-1:0] pending;                 // Buffer awaiting latch
   load_state_t state;                           // Latch walk state
   logic [3:0] walk_idx;                         // Channel under transfer
   logic [CHANNELS-1:0] clear_state;             // Registered clear status

   // ****************************************
   // Bus decode
   // ****************************************
   wire access = psel && penable;                               // Access phase
   wire wr = access && pwrite && (pstrb != 4'h0);               // Write taken
   wire rd_setup = psel && !penable && !pwrite;                 // Read setup
   wire data_hit = in_bank(paddr, OFS_DATA0);                   // Data register
   wire out_hit = in_bank(paddr, OFS_OUT0);                     // Latch readback
   wire [3:0] ch_idx = 4'((paddr - OFS_DATA0) >> 2);            // Data index
   wire [3:0] out_idx = 4'((paddr - OFS_OUT0) >> 2);            // Readback index
   wire reg_hit = hit(paddr, OFS_CTRL) || hit(paddr, OFS_POWER) || hit(paddr, OFS_GAIN)
      || hit(paddr, OFS_CLR0) || hit(paddr, OFS_CLR1) || hit(paddr, OFS_SWCLR)
      || hit(paddr, OFS_AUTO) || hit(paddr, OFS_SYNC) || hit(paddr, OFS_TRIGEN)
      || hit(paddr, OFS_LATCH) || hit(paddr, OFS_STATUS);       // Plain register
   wire mapped = data_hit || out_hit || reg_hit;                // Any register
   wire data_wr = wr && data_hit;                               // Code write
   wire latch_cmd = wr && hit(paddr, OFS_LATCH) && pwdata[LATCH_GO]; // Latch command

   // ****************************************
   // Code buffer memory
   // ****************************************
   wire [3:0] mem_rd_addr = (state == ST_LOAD) ? walk_idx : ch_idx;  // Buffer read port
   logic [CW-1:0] mem_rd_data;                                        // Buffer word

   dac_code_mem #(.DEPTH(CHANNELS), .WIDTH(CW), .AW(4)) u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(data_wr),
      .wr_addr(ch_idx),
      .wr_data(pwdata[CW-1:0]),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data)
   );

   // ****************************************
   // Clear conditions
   // ****************************************
   wire [NUM_TRIG-1:0] trig_vec = {overtemperature_trigger, remote2_low_trigger,
      remote2_high_trigger, remote2_fail_trigger, remote1_low_trigger, remote1_high_trigger,
      remote1_fail_trigger, local_temp_low_trigger, local_temp_high_trigger,
      input_range_trigger};                                     // Trigger sources
   wire any_trig = |(trig_vec & trigger_enable);                // Enabled trigger
   logic [CHANNELS-1:0] next_clear;                             // Clear per channel

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         // Clear from pins, software or triggers
         assign next_clear[g] = (pin0_clear_enable[g] && !clear_input0_n)
            || (pin1_clear_enable[g] && !clear_input1_n)
            || software_clear[g]
            || (trigger_clear_enable[g] && any_trig);

         // Output stage per channel
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dac_code[g*CW +: CW] <= ZERO_CODE;
               dac_active[g] <= 1'b0;
            end else begin
               dac_code[g*CW +: CW] <= next_clear[g] ? ZERO_CODE
                  : out_latch[g*CW +: CW];                   // Zero while cleared
               dac_active[g] <= channel_power_enable[g] && ctrl[CTRL_REF_EN];
            end
         end
      end
   endgenerate

   // ****************************************
   // Latch load: immediate or on command
   // ****************************************
   // Immediate load takes pwdata directly; sync load defers to the walk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_latch <= '0;
         pending <= '0;
         state <= ST_IDLE;
         walk_idx <= 4'h0;
      end else begin
         if (data_wr && !sync_load_enable[ch_idx]) begin
            out_latch[ch_idx*CW +: CW] <= pwdata[CW-1:0];
         end
         case (state)
            ST_IDLE: begin
               if (latch_cmd) begin
                  state <= ST_LOAD;
                  walk_idx <= 4'h0;
               end
            end
            ST_LOAD: begin
               // Memory read data lags its address by one cycle
               if (walk_idx != 4'h0 && pending[walk_idx - 4'h1]) begin
                  out_latch[(walk_idx - 4'h1)*CW +: CW] <= mem_rd_data;
               end
               if (walk_idx == 4'(CHANNELS)) begin
                  state <= ST_DONE;
               end else begin
                  walk_idx <= walk_idx + 4'h1;
               end
            end
            ST_DONE: begin
               pending <= '0;
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
         // A new buffered write marks the channel, winning over the end of a walk
         if (data_wr && sync_load_enable[ch_idx]) begin
            pending[ch_idx] <= 1'b1;
         end
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 32'h0000_0000;                              // Internal ref
         channel_power_enable <= RST_MASK12;
         gain <= RST_MASK12;                                 // Low range
         pin0_clear_enable <= RST_MASK12;
         pin1_clear_enable <= RST_MASK12;
         software_clear <= RST_MASK12;
         trigger_clear_enable <= RST_MASK12;
         sync_load_enable <= RST_MASK12;
         trigger_enable <= RST_TRIGEN;
      end else if (wr) begin
         if (hit(paddr, OFS_CTRL)) begin
            ctrl <= {30'h0, pwdata[CTRL_REF_EN], pwdata[CTRL_REF_EXT]};
         end
         if (hit(paddr, OFS_POWER)) channel_power_enable <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_GAIN)) gain <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_CLR0)) pin0_clear_enable <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_CLR1)) pin1_clear_enable <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_SWCLR)) software_clear <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_AUTO)) trigger_clear_enable <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_SYNC)) sync_load_enable <= pwdata[CHANNELS-1:0];
         if (hit(paddr, OFS_TRIGEN)) trigger_enable <= pwdata[NUM_TRIG-1:0];
      end
   end

   // ****************************************
   // Status, range and reference outputs
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_state <= '0;
         dac_high_range <= '0;
         ref_external <= 1'b0;
      end else begin
         clear_state <= next_clear;
         dac_high_range <= gain;
         ref_external <= ctrl[CTRL_REF_EXT];
      end
   end

   // ****************************************
   // Read mux and APB answer
   // ****************************************
   logic [31:0] next_rdata;                                  // Read value
   always_comb begin
      next_rdata = 32'h0;
      if (data_hit) next_rdata = {20'h0, mem_rd_data};
      else if (out_hit) next_rdata = {20'h0, out_latch[out_idx*CW +: CW]};
      else if (hit(paddr, OFS_CTRL)) next_rdata = ctrl;
      else if (hit(paddr, OFS_POWER)) next_rdata = {20'h0, channel_power_enable};
      else if (hit(paddr, OFS_GAIN)) next_rdata = {20'h0, gain};
      else if (hit(paddr, OFS_CLR0)) next_rdata = {20'h0, pin0_clear_enable};
      else if (hit(paddr, OFS_CLR1)) next_rdata = {20'h0, pin1_clear_enable};
      else if (hit(paddr, OFS_SWCLR)) next_rdata = {20'h0, software_clear};
      else if (hit(paddr, OFS_AUTO)) next_rdata = {20'h0, trigger_clear_enable};
      else if (hit(paddr, OFS_SYNC)) next_rdata = {20'h0, sync_load_enable};
      else if (hit(paddr, OFS_TRIGEN)) next_rdata = {19'h0, trigger_enable};
      else if (hit(paddr, OFS_STATUS)) next_rdata = {20'h0, clear_state};
      else next_rdata = 32'h0;
   end

   // Ready one cycle into the access phase; data buffer read settles in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
         prdata <= (access && !pready && !pwrite) ? next_rdata : 32'h0;
      end
   end
endmodule : dac_channel_control

//--- dac_ctrl_pkg.sv
// Package with register map, field layout and reset values for the DAC channel control
package dac_ctrl_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_CH = 12;                   // Number of channels
   localparam int CODE_W = 12;                   // Code width
   localparam int NUM_TRIG = 13;                 // Clear trigger sources
   localparam int ADDR_W = 12;                   // APB address width
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [11:0] OFS_DATA0 = 12'h000;  // Channel data, one word each
   localparam logic [11:0] OFS_CTRL = 12'h040;   // Reference control
   localparam logic [11:0] OFS_POWER = 12'h044;  // Per-channel power enable
   localparam logic [11:0] OFS_GAIN = 12'h048;   // Per-channel gain
   localparam logic [11:0] OFS_CLR0 = 12'h04C;   // Pin 0 clear enable
   localparam logic [11:0] OFS_CLR1 = 12'h050;   // Pin 1 clear enable
   localparam logic [11:0] OFS_SWCLR = 12'h054;  // Software clear
   localparam logic [11:0] OFS_AUTO = 12'h058;   // Trigger clear enable
   localparam logic [11:0] OFS_SYNC = 12'h05C;   // Sync load enable
   localparam logic [11:0] OFS_TRIGEN = 12'h060; // Trigger source enable
   localparam logic [11:0] OFS_LATCH = 12'h064;  // Latch update command
   localparam logic [11:0] OFS_STATUS = 12'h068; // Clear status per channel
   localparam logic [11:0] OFS_OUT0 = 12'h080;   // Output latch readback
   localparam logic [11:0] DATA_SPAN = 12'h030;  // Bytes spanned by a data bank
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int CTRL_REF_EXT = 0;              // 1 = external reference
   localparam int CTRL_REF_EN = 1;               // Reference block enable
   localparam int LATCH_GO = 0;                  // Write 1 to transfer buffers
   localparam logic [11:0] RST_MASK12 = 12'h000; // Reset of per-channel masks
   localparam logic [11:0] ZERO_CODE = 12'h000;  // Code driven while cleared
   localparam logic [12:0] RST_TRIGEN = 13'h0000;// Trigger enables at reset
endpackage : dac_ctrl_pkg

//--- dac_code_mem.sv
// Small register-file memory holding one code word per channel
`timescale 1ns/1ps
module dac_code_mem #(
   parameter int DEPTH = 12,                 // Words
   parameter int WIDTH = 12,                 // Bits per word
   parameter int AW = 4                      // Address bits
) (
   input wire logic pclk,                    // Clock
   input wire logic presetn,                 // Async reset, active low
   input wire logic wr_en,                   // Write strobe
   input wire logic [AW-1:0] wr_addr,        // Write index
   input wire logic [WIDTH-1:0] wr_data,     // Write data
   input wire logic [AW-1:0] rd_addr,        // Read index
   output logic [WIDTH-1:0] rd_data          // Registered read data
);
   logic [WIDTH-1:0] mem [DEPTH];            // Storage

   // ****************************************
   // Write and registered read
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= (32'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
      end
   end
endmodule : dac_code_mem

//--- dac_channel_control_checker.sv
// Port-level assertion checker for the DAC channel control block
`timescale 1ns/1ps
module dac_channel_control_checker
   import dac_ctrl_pkg::*;
#(
   parameter int CHANNELS = NUM_CH,             // Channel count
   parameter int CW = CODE_W                    // Code width
) (
   input wire logic pclk,                       // Clock
   input wire logic presetn,                    // Reset, active low
   input wire logic psel,                       // APB select
   input wire logic penable,                    // APB enable
   input wire logic pwrite,                     // APB direction
   input wire logic [ADDR_W-1:0] paddr,         // APB address
   input wire logic [31:0] pwdata,              // APB write data
   input wire logic [3:0] pstrb,                // APB strobes
   input wire logic [31:0] prdata,              // APB read data
   input wire logic pready,                     // APB ready
   input wire logic pslverr,                    // APB error
   input wire logic clear_input0_n,             // Clear pin 0
   input wire logic clear_input1_n,             // Clear pin 1
   input wire logic [3:0] input_range_trigger,  // Range triggers
   input wire logic local_temp_high_trigger,    // Local high
   input wire logic local_temp_low_trigger,     // Local low
   input wire logic remote1_fail_trigger,       // Remote 1 fail
   input wire logic remote1_high_trigger,       // Remote 1 high
   input wire logic remote1_low_trigger,        // Remote 1 low
   input wire logic remote2_fail_trigger,       // Remote 2 fail
   input wire logic remote2_high_trigger,       // Remote 2 high
   input wire logic remote2_low_trigger,        // Remote 2 low
   input wire logic overtemperature_trigger,    // Overtemperature
   input wire logic [CHANNELS*CW-1:0] dac_code, // Codes
   input wire logic [CHANNELS-1:0] dac_active,  // Driven channels
   input wire logic [CHANNELS-1:0] dac_high_range, // Range select
   input wire logic ref_external                // Reference source
);
   // ****************************************
   // Shadow of the control words
   // ****************************************
   logic [31:0] shadow [0:8];              // Words 0x040 to 0x060
   logic [3:0] slot;                       // Shadow index
   logic wr_done;                          // Completed good write
   logic [12:0] trig;                      // Trigger inputs
   logic [CHANNELS-1:0] clr_mask;          // Channels held clear
   logic [CHANNELS-1:0] code_zero;         // Channels showing zero
   assign slot = paddr[5:2];
   assign wr_done = psel && penable && pready && pwrite && (|pstrb) && !pslverr
      && paddr >= OFS_CTRL && paddr <= OFS_TRIGEN;
   assign trig = {overtemperature_trigger, remote2_low_trigger, remote2_high_trigger,
      remote2_fail_trigger, remote1_low_trigger, remote1_high_trigger,
      remote1_fail_trigger, local_temp_low_trigger, local_temp_high_trigger,
      input_range_trigger};
   assign clr_mask = (shadow[3][CHANNELS-1:0] & {CHANNELS{!clear_input0_n}})
      | (shadow[4][CHANNELS-1:0] & {CHANNELS{!clear_input1_n}}) | shadow[5][CHANNELS-1:0]
      | (shadow[6][CHANNELS-1:0] & {CHANNELS{|(trig & shadow[8][12:0])}});
   for (genvar g = 0; g < CHANNELS; g++) begin : g_zero
      assign code_zero[g] = (dac_code[g*CW +: CW] == '0);
   end
   // Track control words as each write completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 9; i++) begin
            shadow[i] <= 32'h0;
         end
      end else if (wr_done) begin
         shadow[slot] <= pwdata;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   pready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("ready missing in second access cycle");
   pready_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero while idle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   ref_source_a: assert property (ref_external == shadow[0][CTRL_REF_EXT])
      else $error("reference source differs from control");
   active_gate_a: assert property (dac_active ==
      (shadow[1][CHANNELS-1:0] & {CHANNELS{shadow[0][CTRL_REF_EN]}}))
      else $error("active channels differ from power and enable");
   gain_range_a: assert property (dac_high_range == shadow[2][CHANNELS-1:0])
      else $error("range differs from gain");
   clear_zero_a: assert property ((clr_mask & $past(clr_mask) & $past(clr_mask, 2)
      & ~code_zero) == '0)
      else $error("cleared channel shows nonzero code");
endmodule : dac_channel_control_checker

//--- tb.sv
// Self-checking testbench for the DAC channel control block
`timescale 1ns/1ps
module tb;
   import dac_ctrl_pkg::*;
   logic pclk = 1'h0; // Clock
   logic presetn = 1'h0; // Reset, active low
   logic psel = 1'h0; // APB select
   logic penable = 1'h0; // APB enable
   logic pwrite = 1'h0; // APB direction
   logic [ADDR_W-1:0] paddr = 12'h000; // APB address
   logic [31:0] pwdata = 32'h0; // APB write data
   logic [3:0] pstrb = 4'hF; // APB strobes
   logic [31:0] prdata; // APB read data
   logic pready; // APB ready
   logic pslverr; // APB error
   logic [1:0] pins_n = 2'h3; // Clear pins, active low
   logic [12:0] trig = 13'h0; // Trigger inputs
   logic [NUM_CH*CODE_W-1:0] dac_code; // Codes
   logic [NUM_CH-1:0] dac_active; // Driven channels
   logic [NUM_CH-1:0] dac_high_range; // Range select
   logic ref_external; // Reference source
   logic [31:0] rd; // Last read data
   logic err; // Last error flag
   int n_errors = 0; // Mismatches
   int num_checks = 0; // Comparisons
   logic [11:0] offs [10] = '{OFS_CTRL, OFS_POWER, OFS_GAIN, OFS_CLR0, OFS_CLR1,
      OFS_SWCLR, OFS_AUTO, OFS_SYNC, OFS_TRIGEN, OFS_STATUS}; // Control and status registers
   // Clock generation
   always #5 pclk = ~pclk;
   dac_channel_control dac_channel_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .clear_input0_n(pins_n[0]),
      .clear_input1_n(pins_n[1]), .input_range_trigger(trig[3:0]),
      .local_temp_high_trigger(trig[4]), .local_temp_low_trigger(trig[5]),
      .remote1_fail_trigger(trig[6]), .remote1_high_trigger(trig[7]),
      .remote1_low_trigger(trig[8]), .remote2_fail_trigger(trig[9]),
      .remote2_high_trigger(trig[10]), .remote2_low_trigger(trig[11]),
      .overtemperature_trigger(trig[12]), .dac_code(dac_code), .dac_active(dac_active),
      .dac_high_range(dac_high_range), .ref_external(ref_external));
   // ****************************************
   // Tasks
   // ****************************************
   // One APB transfer, held until ready, then one settling edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (k >= 20) begin
         n_errors++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : xfer
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : chk
   // Read a register and compare
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'h0, a, 32'h0);
      chk($sformatf("register %h", a), rd, exp);
   endtask : rdc
   // Drive pins and triggers, then let the clear settle
   task automatic drive(input logic [1:0] p, input logic [12:0] t);
      @(posedge pclk);
      pins_n <= p;
      trig <= t;
      repeat (3) @(posedge pclk);
   endtask : drive
   // Code of one channel
   function automatic logic [11:0] code(input int n);
      return dac_code[n*CODE_W +: CODE_W];
   endfunction : code
   // Counts and verdict
   task automatic results;
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      foreach (offs[i]) rdc(offs[i], 32'h0);
      chk("reference", ref_external, 32'h0);
      xfer(1'h0, 12'h06C, 32'h0);
      chk("unmapped error", err, 32'h1);
      chk("unmapped data", rd, 32'h0);
      rdc(OFS_LATCH, 32'h0);
      $display("test reset done");
      xfer(1'h1, OFS_POWER, 32'hFFF);
      chk("active gated", dac_active, 32'h0);
      xfer(1'h1, OFS_CTRL, 32'h3);
      chk("active", dac_active, 32'hFFF);
      chk("reference", ref_external, 32'h1);
      xfer(1'h1, OFS_POWER, 32'hA5A);
      chk("active mask", dac_active, 32'hA5A);
      xfer(1'h1, OFS_GAIN, 32'h801);
      chk("gain", dac_high_range, 32'h801);
      xfer(1'h1, OFS_GAIN, 32'h0);
      chk("gain back", dac_high_range, 32'h0);
      pstrb <= 4'h0;
      xfer(1'h1, OFS_GAIN, 32'hFFF);
      pstrb <= 4'hF;
      chk("no strobe error", err, 32'h0);
      rdc(OFS_GAIN, 32'h0);
      $display("test power and range done");
      for (int n = 0; n < NUM_CH; n++) begin
         xfer(1'h1, OFS_DATA0 + 12'(4 * n), 32'hFFF - n);
         chk("direct code", code(n), 32'hFFF - n);
         rdc(OFS_OUT0 + 12'(4 * n), 32'hFFF - n);
      end
      xfer(1'h1, OFS_SYNC, 32'h8);
      xfer(1'h1, OFS_DATA0 + 12'h00C, 32'h123);
      chk("held code", code(3), 32'hFFC);
      xfer(1'h1, OFS_LATCH, 32'h1);
      repeat (16) @(posedge pclk);
      chk("latched code", code(3), 32'h123);
      rdc(OFS_DATA0 + 12'h00C, 32'h123);
      $display("test load done");
      xfer(1'h1, OFS_SWCLR, 32'h20);
      chk("soft clear", code(5), 32'h0);
      rdc(OFS_STATUS, 32'h20);
      xfer(1'h1, OFS_SWCLR, 32'h0);
      chk("soft release", code(5), 32'hFFA);
      xfer(1'h1, OFS_CLR0, 32'h1);
      xfer(1'h1, OFS_CLR1, 32'h2);
      drive(2'h2, 13'h0);
      chk("pin0 clear", code(0), 32'h0);
      chk("pin0 other", code(1), 32'hFFE);
      drive(2'h1, 13'h0);
      chk("pin1 clear", code(1), 32'h0);
      chk("pin1 other", code(0), 32'hFFF);
      drive(2'h3, 13'h0);
      xfer(1'h1, OFS_AUTO, 32'h4);
      drive(2'h3, 13'h1FFF);
      chk("trigger masked", code(2), 32'hFFD);
      drive(2'h3, 13'h0);
      xfer(1'h1, OFS_TRIGEN, 32'h1FFF);
      for (int t = 0; t < NUM_TRIG; t++) begin
         drive(2'h3, 13'h1 << t);
         chk("trigger clear", code(2), 32'h0);
         drive(2'h3, 13'h0);
         chk("trigger release", code(2), 32'hFFD);
      end
      $display("test clears done");
      results();
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      results();
   end
endmodule : tb
bind dac_channel_control dac_channel_control_checker #(.CHANNELS(CHANNELS), .CW(CW))
   dac_channel_control_checker_i (.*);
